// file: rtl/acu_core.v
// Purpose: Accumulator datapath with table conversions and flags.
// Assumes: Memory read data is valid while mem_rd_en_q is high.
// Notes:   One operation at a time; busy blocks new commands.
`timescale 1ns/1ps
`include "acu_defs.vh"
module acu_core (
    // Clock, reset and enable.
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        clk_en,
    // Command port.
    input  wire        cmd_valid,
    input  wire [2:0]  cmd_op,
    input  wire [31:0] cmd_operand,
    // Variable memory port, 16-bit words.
    output reg         mem_rd_en_q,
    output reg         mem_wr_en_q,
    output reg  [15:0] mem_addr_q,
    output reg  [15:0] mem_wdata_q,
    input  wire [15:0] mem_rdata,
    // Visible state.
    output reg  [31:0] acc_q,
    output reg  [31:0] stack1_q,
    output reg         busy_q,
    output reg         done_q,
    output reg         operand_overflow_flag,
    output reg         result_zero_flag,
    output reg         result_negative_flag
);

    // ----------------------------------------------------------------
    // Table walk states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;            // Waiting for a command.
    localparam [2:0] ST_RD   = 3'h1;            // Issue a source read.
    localparam [2:0] ST_WAIT = 3'h2;            // Read data returns.
    localparam [2:0] ST_WR   = 3'h3;            // Write one result word.
    localparam [2:0] ST_WR2  = 3'h4;            // Second word of expansion.

    reg  [2:0]  state_q;                        // Walk state.
    reg  [2:0]  op_q;                           // Operation in flight.
    reg  [15:0] src_q;                          // Next source address.
    reg  [15:0] dst_q;                          // Next destination address.
    reg  [15:0] left_q;                         // Source words remaining.
    reg         half_q;                         // Second source word of a pair.
    reg  [7:0]  pack_q;                         // Packed byte of the latest source word.
    reg  [15:0] word_q;                         // Held source word.

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Character code to digit; bit 4 marks an illegal code.
    function [4:0] ch2hex;
        input [7:0] c;
        begin
            if (c >= `ACU_CH_ZERO && c <= `ACU_CH_NINE)
                ch2hex = {1'b0, c[3:0]};
            else if (c >= `ACU_CH_UA && c <= `ACU_CH_UF)
                ch2hex = {1'b0, c[3:0] + 4'h9};
            else
                ch2hex = 5'h10;
        end
    endfunction

    // Digit to character code.
    function [7:0] hex2ch;
        input [3:0] d;
        begin
            if (d <= 4'h9)
                hex2ch = `ACU_CH_ZERO + {4'h0, d};
            else
                hex2ch = `ACU_CH_UA + {4'h0, d - 4'ha};
        end
    endfunction

    // Gray to binary, then binary to 10-bit BCD (values up to 399).
    function [15:0] gray2bin;
        input [15:0] g;
        integer k;
        begin
            gray2bin[15] = g[15];
            for (k = 14; k >= 0; k = k - 1)
                gray2bin[k] = gray2bin[k+1] ^ g[k];
        end
    endfunction

    function [15:0] bin2bcd;
        input [9:0] b;
        integer k;
        reg [25:0] sh;
        begin
            sh = {16'h0000, b};
            for (k = 0; k < 10; k = k + 1) begin
                if (sh[13:10] > 4'h4) sh[13:10] = sh[13:10] + 4'h3;
                if (sh[17:14] > 4'h4) sh[17:14] = sh[17:14] + 4'h3;
                if (sh[21:18] > 4'h4) sh[21:18] = sh[21:18] + 4'h3;
                if (sh[25:22] > 4'h4) sh[25:22] = sh[25:22] + 4'h3;
                sh = {sh[24:0], 1'b0};
            end
            bin2bcd = sh[25:10];
        end
    endfunction

    // ----------------------------------------------------------------
    // Shuffle network and conversions
    // ----------------------------------------------------------------
    wire [31:0] shuf_w;                         // Shuffled digits.
    acu_shuffle u_shuffle (
        .src_digits (stack1_q),
        .order_spec (acc_q),
        .shuffled   (shuf_w)
    );

    wire [15:0] gbin_w = gray2bin(acc_q[15:0]);
    // Position is the low ten binary bits; counts below 400 map directly.
    wire [15:0] gbcd_w = bin2bcd(gbin_w[9:0]);
    wire [31:0] gray_res_w = {`ACU_HI_ZERO, gbcd_w[9:0]};
    // Offsets for 360/720 count encoders are left to the program.

    wire [4:0]  hi_w = ch2hex(mem_rdata[15:8]);
    wire [4:0]  lo_w = ch2hex(mem_rdata[7:0]);
    wire        start_w = cmd_valid && !busy_q;

    // ----------------------------------------------------------------
    // Main datapath
    // ----------------------------------------------------------------
    // Flags are touched only by operations that own them, so they hold
    // between such operations.
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            acc_q                 <= 32'h00000000;
            stack1_q              <= 32'h00000000;
            busy_q                <= 1'b0;
            done_q                <= 1'b0;
            state_q               <= ST_IDLE;
            op_q                  <= `ACU_OP_NONE;
            src_q                 <= 16'h0000;
            dst_q                 <= 16'h0000;
            left_q                <= 16'h0000;
            half_q                <= 1'b0;
            pack_q                <= 8'h00;
            word_q                <= 16'h0000;
            mem_rd_en_q           <= 1'b0;
            mem_wr_en_q           <= 1'b0;
            mem_addr_q            <= 16'h0000;
            mem_wdata_q           <= 16'h0000;
            operand_overflow_flag <= 1'b0;
            result_zero_flag      <= 1'b0;
            result_negative_flag  <= 1'b0;
        end else if (clk_en) begin
            done_q      <= 1'b0;
            mem_rd_en_q <= 1'b0;
            mem_wr_en_q <= 1'b0;
            case (state_q)
            ST_IDLE: begin
                if (start_w) begin
                    case (cmd_op)
                    `ACU_OP_LOAD: begin
                        stack1_q <= acc_q;
                        acc_q    <= cmd_operand;
                        done_q   <= 1'b1;
                    end
                    `ACU_OP_INV: begin
                        acc_q  <= ~acc_q;
                        done_q <= 1'b1;
                    end
                    `ACU_OP_GRAY: begin
                        acc_q                <= gray_res_w;
                        result_zero_flag     <= (gray_res_w == 32'h00000000);
                        result_negative_flag <= gray_res_w[31];
                        done_q               <= 1'b1;
                    end
                    `ACU_OP_SHUF: begin
                        // Digits in stack, order in accumulator.
                        acc_q                <= shuf_w;
                        result_zero_flag     <= (shuf_w == 32'h00000000);
                        result_negative_flag <= shuf_w[31];
                        done_q               <= 1'b1;
                    end
                    `ACU_OP_ATOH, `ACU_OP_HTOA: begin
                        // Count in stack, source in accumulator.
                        operand_overflow_flag <= (acc_q[31:16] != 16'h0000) ||
                                                 (stack1_q[31:16] != 16'h0000);
                        op_q   <= cmd_op;
                        src_q  <= acc_q[15:0];
                        dst_q  <= cmd_operand[15:0];
                        left_q <= stack1_q[15:0];
                        half_q <= 1'b0;
                        if (acc_q[31:16] != 16'h0000 || stack1_q[31:16] != 16'h0000 ||
                            stack1_q[15:0] == 16'h0000) begin
                            done_q <= 1'b1;
                        end else begin
                            busy_q  <= 1'b1;
                            state_q <= ST_RD;
                        end
                    end
                    default: begin
                        done_q <= 1'b1;
                    end
                    endcase
                end
            end
            ST_RD: begin
                mem_rd_en_q <= 1'b1;
                mem_addr_q  <= src_q;
                src_q       <= src_q + 16'h0001;
                left_q      <= left_q - 16'h0001;
                state_q     <= ST_WAIT;
            end
            ST_WAIT: begin
                // Read data is valid this cycle. The packing path keeps its
                // first byte in word_q, so only the expansion path reloads it.
                state_q <= ST_WR;
                if (op_q == `ACU_OP_ATOH) begin
                    if (hi_w[4] || lo_w[4])
                        operand_overflow_flag <= 1'b1;
                    pack_q <= {hi_w[3:0], lo_w[3:0]};
                end else begin
                    word_q <= mem_rdata;
                end
            end
            ST_WR: begin
                if (op_q == `ACU_OP_ATOH) begin
                    if (!half_q && left_q != 16'h0000) begin
                        half_q  <= 1'b1;
                        word_q  <= {pack_q, 8'h00};
                        state_q <= ST_RD;
                    end else begin
                        mem_wr_en_q <= 1'b1;
                        mem_addr_q  <= dst_q;
                        mem_wdata_q <= half_q ? {word_q[15:8], pack_q} : {pack_q, 8'h00};
                        dst_q       <= dst_q + 16'h0001;
                        half_q      <= 1'b0;
                        state_q     <= (left_q == 16'h0000) ? ST_IDLE : ST_RD;
                    end
                end else begin
                    mem_wr_en_q <= 1'b1;
                    mem_addr_q  <= dst_q;
                    mem_wdata_q <= {hex2ch(word_q[15:12]), hex2ch(word_q[11:8])};
                    dst_q       <= dst_q + 16'h0001;
                    state_q     <= ST_WR2;
                end
                if (op_q == `ACU_OP_ATOH && left_q == 16'h0000 &&
                    (half_q || left_q == 16'h0000)) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
            ST_WR2: begin
                mem_wr_en_q <= 1'b1;
                mem_addr_q  <= dst_q;
                mem_wdata_q <= {hex2ch(word_q[7:4]), hex2ch(word_q[3:0])};
                dst_q       <= dst_q + 16'h0001;
                if (left_q == 16'h0000) begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                    done_q  <= 1'b1;
                end else begin
                    state_q <= ST_RD;
                end
            end
            default: begin
                state_q <= ST_IDLE;
                busy_q  <= 1'b0;
            end
            endcase
        end
    end

endmodule // acu_core

// file: common/acu_defs.vh
// Purpose: Constants for the accumulator conversion unit.
// Assumes: Included by the design files by bare name.
// Notes:   Operation codes, table character codes and width limits.
`ifndef ACU_DEFS_VH
`define ACU_DEFS_VH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define ACU_OP_NONE    3'h0
`define ACU_OP_LOAD    3'h1
`define ACU_OP_INV     3'h2
`define ACU_OP_ATOH    3'h3
`define ACU_OP_HTOA    3'h4
`define ACU_OP_GRAY    3'h5
`define ACU_OP_SHUF    3'h6

// ----------------------------------------------------------------
// Character codes for the table conversions
// ----------------------------------------------------------------
`define ACU_CH_ZERO    8'h30
`define ACU_CH_NINE    8'h39
`define ACU_CH_UA      8'h41
`define ACU_CH_UF      8'h46

// ----------------------------------------------------------------
// Widths and limits
// ----------------------------------------------------------------
`define ACU_GRAY_BITS  16
`define ACU_ADDR_MAX   16'hffff
`define ACU_HI_ZERO    22'h000000

`endif

// file: rtl/acu_shuffle.v
// Purpose: Combinational digit shuffle of up to eight hex digits.
// Assumes: Source digits and order word are stable while sampled.
// Notes:   Pure logic; the caller registers the result.
`timescale 1ns/1ps
module acu_shuffle (
    // Operands.
    input  wire [31:0] src_digits,
    input  wire [31:0] order_spec,
    // Result.
    output reg  [31:0] shuffled
);

    // ----------------------------------------------------------------
    // Shuffle network
    // ----------------------------------------------------------------
    // Order digit k (1..8) picks source digit k-1 for that result slot.
    // Scanning from the most significant slot down lets the most significant
    // user of a repeated digit number claim it first; later users stay zero.
    integer i;
    reg     [8:0] owner;                        // Digit number already claimed.
    reg     [3:0] od;                           // Current order digit.
    always @* begin
        shuffled = 32'h00000000;
        owner    = 9'h000;
        od       = 4'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            od = order_spec[i*4 +: 4];
            if (od >= 4'h1 && od <= 4'h8) begin
                if (!owner[od]) begin
                    owner[od] = 1'b1;
                    shuffled[i*4 +: 4] = src_digits[(od-1)*4 +: 4];
                end
            end
            // Digits 0 and 9-F leave the slot at zero.
        end
    end

endmodule // acu_shuffle

// file: test/acu_core_sva.sv
// Purpose: Concurrent checks on the accumulator unit ports.
// Assumes: One clock domain; reset_n is synchronous and active low.
// Notes:   Bound into every acu_core instance after the module.
`timescale 1ns/1ps
`include "acu_defs.vh"
module acu_core_sva (
    // Clock, reset and enable.
    input wire        sys_clk,
    input wire        reset_n,
    input wire        clk_en,
    // Command port.
    input wire        cmd_valid,
    input wire [2:0]  cmd_op,
    input wire [31:0] cmd_operand,
    // Visible state.
    input wire [31:0] acc_q,
    input wire [31:0] stack1_q,
    input wire        busy_q,
    input wire        done_q,
    input wire        operand_overflow_flag,
    input wire        result_zero_flag,
    input wire        result_negative_flag
);
    // A command is only taken while idle and enabled.
    wire take = cmd_valid && !busy_q && clk_en;
    // Table ops are refused when either operand overflows 16 bits.
    wire table_op = (cmd_op == `ACU_OP_ATOH) || (cmd_op == `ACU_OP_HTOA);
    wire big = (acc_q[31:16] != 16'h0000) || (stack1_q[31:16] != 16'h0000);
    wire flag_op = (cmd_op == `ACU_OP_GRAY) || (cmd_op == `ACU_OP_SHUF);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    load_push_a: assert property (take && cmd_op == `ACU_OP_LOAD |=>
        acc_q == $past(cmd_operand) && stack1_q == $past(acc_q) && done_q)
        else $error("load did not push the old accumulator");
    invert_all_a: assert property (take && cmd_op == `ACU_OP_INV |=>
        acc_q == ~$past(acc_q)) else $error("invert result wrong");
    gray_high_a: assert property (take && cmd_op == `ACU_OP_GRAY |=>
        acc_q[31:10] == 22'h000000) else $error("gray upper bits not cleared");
    zero_flag_a: assert property (take && flag_op |=>
        result_zero_flag == (acc_q == 32'h00000000)) else $error("zero flag wrong");
    neg_flag_a: assert property (take && flag_op |=>
        result_negative_flag == acc_q[31]) else $error("negative flag wrong");
    flag_hold_a: assert property (take && cmd_op <= `ACU_OP_INV |=>
        $stable(result_zero_flag) && $stable(result_negative_flag))
        else $error("flags changed by an op that does not own them");
    oversize_a: assert property (take && table_op && big |=>
        operand_overflow_flag && done_q && !busy_q) else $error("oversize not refused");
    busy_end_a: assert property ($rose(busy_q) |-> ##[1:200] !busy_q)
        else $error("table op never finished");
    freeze_a: assert property (!clk_en |=> $stable(acc_q) && $stable(stack1_q))
        else $error("state moved while disabled");
endmodule // acu_core_sva

bind acu_core acu_core_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_operand(cmd_operand), .acc_q(acc_q),
    .stack1_q(stack1_q), .busy_q(busy_q), .done_q(done_q),
    .operand_overflow_flag(operand_overflow_flag), .result_zero_flag(result_zero_flag),
    .result_negative_flag(result_negative_flag));

// file: test/testbench.sv
// Purpose: Directed bench for the accumulator conversion unit.
// Assumes: Memory read data follows the read strobe within the same cycle.
// Notes:   Inputs change at the falling edge; memory acts on the rising edge.
`timescale 1ns/1ps
`include "acu_defs.vh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module testbench;
    // --------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------
    reg         sys_clk = 1'b0;       // 10 MHz clock.
    reg         reset_n = 1'b0;       // Synchronous reset, active low.
    reg         clk_en = 1'b1;        // Global enable.
    reg         cmd_valid = 1'b0;     // Command request.
    reg  [2:0]  cmd_op = 3'h0;        // Operation code.
    reg  [31:0] cmd_operand = 32'h0;  // Load value or destination.
    wire [15:0] mem_rdata;            // Read data from the memory model.
    reg  [15:0] mem [0:255];          // Small variable memory.
    wire        mem_rd_en_q, mem_wr_en_q, busy_q, done_q;
    wire [15:0] mem_addr_q, mem_wdata_q;
    wire [31:0] acc_q, stack1_q;
    wire        ovf, zf, nf;
    integer     mismatches = 0;       // Failed comparisons.
    integer     n_compared = 0;       // All comparisons.
    acu_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_operand(cmd_operand),
        .mem_rd_en_q(mem_rd_en_q), .mem_wr_en_q(mem_wr_en_q), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .acc_q(acc_q),
        .stack1_q(stack1_q), .busy_q(busy_q), .done_q(done_q),
        .operand_overflow_flag(ovf), .result_zero_flag(zf), .result_negative_flag(nf));
    initial forever #50 sys_clk = ~sys_clk;
    // Memory model: writes land at the edge, reads answer within the strobe cycle.
    // Outside reads the bus shows the inverse word, so a mistimed sample is caught.
    always @(posedge sys_clk) begin
        if (mem_wr_en_q) mem[mem_addr_q[7:0]] <= mem_wdata_q;
    end
    assign mem_rdata = mem_rd_en_q ? mem[mem_addr_q[7:0]] : ~mem[mem_addr_q[7:0]];
    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    // One command, then a bounded wait for its completion pulse.
    task run(input [2:0] op, input [31:0] arg);
        integer k;
        begin
            @(negedge sys_clk);
            cmd_op = op; cmd_operand = arg; cmd_valid = 1'b1;
            @(negedge sys_clk);
            cmd_valid = 1'b0;
            k = 0;
            while (done_q !== 1'b1 && k < 300) begin
                @(negedge sys_clk);
                k++;
            end
            `CHK("done", 1'b1, done_q)
            // One more edge lets a final memory write, registered with done, land.
            @(negedge sys_clk);
        end
    endtask
    // Gray to binary, low ten bits to BCD, ten bits kept.
    function [31:0] gray_exp(input [15:0] g);
        reg [15:0] b;
        integer i, n;
        begin
            b[15] = g[15];
            for (i = 14; i >= 0; i--) b[i] = b[i+1] ^ g[i];
            n = b[9:0];
            gray_exp = ((n / 1000) * 4096 + ((n / 100) % 10) * 256 +
                        ((n / 10) % 10) * 16 + n % 10) & 32'h3ff;
        end
    endfunction
    // Order nibble k in 1..8 picks source digit k, counted from the low end.
    function [31:0] shuf_exp(input [31:0] s, input [31:0] o);
        integer i, j;
        reg [3:0] d;
        reg dup;
        begin
            shuf_exp = 32'h0;
            for (i = 0; i < 8; i++) begin
                d = o[4*i+:4];
                dup = 1'b0;
                for (j = i + 1; j < 8; j++) if (o[4*j+:4] == d) dup = 1'b1;
                if (d >= 1 && d <= 8 && !dup) shuf_exp[4*i+:4] = s[4*(d-1)+:4];
            end
        end
    endfunction
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task t_load_inv;
        begin
            run(`ACU_OP_LOAD, 32'h1234abcd);
            run(`ACU_OP_LOAD, 32'hf00f0ff0);
            `CHK("stack1", 32'h1234abcd, stack1_q)
            run(`ACU_OP_INV, 32'h0);
            `CHK("acc", 32'h0ff0f00f, acc_q)
            @(negedge sys_clk);
            clk_en = 1'b0; cmd_op = `ACU_OP_LOAD; cmd_valid = 1'b1;
            repeat (2) @(negedge sys_clk);
            `CHK("frozen acc", 32'h0ff0f00f, acc_q)
            cmd_valid = 1'b0; clk_en = 1'b1;
        end
    endtask
    task t_gray;
        reg [15:0] g [0:3];
        integer i;
        begin
            g[0] = 16'h0000; g[1] = 16'h0200; g[2] = 16'h01d4; g[3] = 16'hffff;
            for (i = 0; i < 4; i++) begin
                run(`ACU_OP_LOAD, {16'hffff, g[i]});
                // Raw results only; offsets for other encoders stay with the program.
                run(`ACU_OP_GRAY, 32'h0);
                `CHK("gray acc", gray_exp(g[i]), acc_q)
                `CHK("gray zero", (g[i] == 16'h0000), zf)
                `CHK("gray neg", 1'b0, nf)
            end
        end
    endtask
    task t_shuffle;
        reg [31:0] s [0:4];
        reg [31:0] o [0:4];
        integer i;
        begin
            s[0] = 32'h87654321; o[0] = 32'h12345678;
            s[1] = 32'h12345678; o[1] = 32'h10a9f234;
            s[2] = 32'habcdef12; o[2] = 32'h81818181;
            s[3] = 32'h80000000; o[3] = 32'h88888888;
            s[4] = 32'h5a5a5a5a; o[4] = 32'h00000000;
            for (i = 0; i < 5; i++) begin
                run(`ACU_OP_LOAD, s[i]);
                run(`ACU_OP_LOAD, o[i]);
                run(`ACU_OP_SHUF, 32'h0);
                `CHK("shuffle", shuf_exp(s[i], o[i]), acc_q)
                `CHK("shuf zero", (shuf_exp(s[i], o[i]) == 0), zf)
                `CHK("shuf neg", shuf_exp(s[i], o[i]) >> 31, {31'h0, nf})
            end
        end
    endtask
    task t_ath;
        begin
            mem[16] = 16'h3132; mem[17] = 16'h4146; mem[18] = 16'h3039; mem[19] = 16'h4345;
            mem[34] = 16'h5a5a;
            run(`ACU_OP_LOAD, 32'h4);
            run(`ACU_OP_LOAD, 32'h10);
            run(`ACU_OP_ATOH, 32'h20);
            `CHK("ath w0", 16'h12af, mem[32])
            `CHK("ath w1", 16'h09ce, mem[33])
            `CHK("ath end", 16'h5a5a, mem[34])
            `CHK("ath ovf", 1'b0, ovf)
            mem[16] = 16'h3a32;
            run(`ACU_OP_LOAD, 32'h2);
            run(`ACU_OP_LOAD, 32'h10);
            run(`ACU_OP_ATOH, 32'h24);
            `CHK("bad char ovf", 1'b1, ovf)
            run(`ACU_OP_LOAD, 32'h2);
            run(`ACU_OP_LOAD, 32'h00010010);
            run(`ACU_OP_ATOH, 32'h22);
            `CHK("big ovf", 1'b1, ovf)
            `CHK("big untouched", 16'h5a5a, mem[34])
        end
    endtask
    task t_hta;
        begin
            mem[48] = 16'h1a2f; mem[49] = 16'h09bc; mem[68] = 16'ha5a5;
            run(`ACU_OP_LOAD, 32'h2);
            run(`ACU_OP_LOAD, 32'h30);
            run(`ACU_OP_HTOA, 32'h40);
            `CHK("hta w0", 16'h3141, mem[64])
            `CHK("hta w1", 16'h3246, mem[65])
            `CHK("hta w2", 16'h3039, mem[66])
            `CHK("hta w3", 16'h4243, mem[67])
            `CHK("hta end", 16'ha5a5, mem[68])
            `CHK("hta ovf", 1'b0, ovf)
        end
    endtask
    // --------------------------------------------------------
    // Verdict and main sequence
    // --------------------------------------------------------
    task tally_and_finish;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // Watchdog: the whole sequence needs well under 2000 cycles.
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        `CHK("reset acc", 32'h0, acc_q)
        t_load_inv;
        t_gray;
        t_shuffle;
        t_ath;
        t_hta;
        tally_and_finish;
    end
endmodule // testbench
